// *** snt_link.sv ***
// Single-wire nibble link: APB registers, frame transmitter and receiver
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module snt_link import snt_pkg::*; #(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_rx,
    output logic link_tx,
    output logic frame_event
);
    // ********************************************************************
    // Elaboration check
    // ********************************************************************
    if (CNT_W != 16) begin : g_bad_width
        $error("snt_link: register fields are 16 bits wide");
    end

    logic [15:0] con1_ff, con2_ff, con3_ff, datl_ff, dath_ff, sync_ff;
    logic done_ff, ferr_ff, cerr_ff, trig_req_ff;
    logic [31:0] prdata_ff;
    snt_cfg_t cfg;
    logic wr_en, rd_setup, addr_hit, trig_wr;
    logic [2:0] nib_n;
    logic pre_en, tick, tx_run, rx_run;

    assign cfg = '{enable: con1_ff[B_ENABLE], recv: con1_ff[B_RECV], trig: con1_ff[B_TRIG],
                   inv: con1_ff[B_INV], crc: con1_ff[B_CRC], pause: con1_ff[B_PAUSE],
                   div4: con1_ff[B_DIV], nib: con1_ff[B_NIB +: 3]};
    assign tx_run = cfg.enable && !cfg.recv;
    assign rx_run = cfg.enable && cfg.recv;
    // Direct code, clamped into the legal range
    assign nib_n = (cfg.nib < 3'(MIN_NIB)) ? 3'(MIN_NIB) : (cfg.nib > 3'(MAX_NIB)) ? 3'(MAX_NIB) : cfg.nib;

    // ********************************************************************
    // APB slave: zero wait, read data latched in setup phase
    // ********************************************************************
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign addr_hit = paddr inside {OFF_CON1, OFF_CON2, OFF_CON3, OFF_DATL, OFF_DATH, OFF_SYNC, OFF_STAT};
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign prdata = prdata_ff;
    assign trig_wr = wr_en && paddr == OFF_STAT && pwdata[S_TRIG];

    // Read mux sampled one cycle before the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                OFF_CON1: prdata_ff <= {16'h0000, con1_ff};
                OFF_CON2: prdata_ff <= {16'h0000, con2_ff};
                OFF_CON3: prdata_ff <= {16'h0000, con3_ff};
                OFF_DATL: prdata_ff <= {16'h0000, datl_ff};
                OFF_DATH: prdata_ff <= {16'h0000, dath_ff};
                OFF_SYNC: prdata_ff <= {16'h0000, sync_ff};
                OFF_STAT: prdata_ff <= {23'h000000, trig_req_ff, 3'h0, rx_run, tx_run, cerr_ff, ferr_ff, done_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Control registers; reserved bits stay zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con1_ff <= CON1_RST;
            con2_ff <= CON2_RST;
            con3_ff <= CON3_RST;
        end else if (wr_en) begin
            if (paddr == OFF_CON1) con1_ff <= pwdata[15:0] & CON1_MASK;
            if (paddr == OFF_CON2) con2_ff <= pwdata[15:0];
            if (paddr == OFF_CON3) con3_ff <= pwdata[15:0];
        end
    end

    snt_tick #(.CNT_W(CNT_W)) u_tick (
        .clk(pclk),
        .rst_n(presetn),
        .run(cfg.enable),
        .div4(cfg.div4),
        .divider(con2_ff),
        .pre_en(pre_en),
        .tick(tick)
    );

    // ********************************************************************
    // CRC helper: seeded 4-bit CRC over data nibbles plus a zero nibble
    // ********************************************************************
    function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [3:0] d);
        logic [3:0] r;
        r = c ^ d;
        for (int b = 0; b < 4; b++) begin
            r = r[3] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic [3:0] crc_frame(input logic [31:0] w, input logic [2:0] n);
        logic [3:0] c;
        c = CRC_SEED;
        for (int k = 1; k <= MAX_NIB; k++) begin
            if (k <= int'(n)) c = crc_step(c, w[31-4*k -: 4]);
        end
        return crc_step(c, 4'h0);
    endfunction

    // ********************************************************************
    // Transmitter
    // ********************************************************************
    snt_tx_state_t tx_state_ff;
    logic [10:0] tcnt_ff, tx_len;  // 11 bits: a capped frame leaves a pause near 1900 ticks
    logic [2:0] nidx_ff;
    logic [11:0] fticks_ff, frame_cap;
    logic [3:0] tx_nib, tx_crc;
    logic tx_last, tx_line;
    logic [31:0] tx_word;

    assign tx_word = {dath_ff, datl_ff};
    // Software CRC used when hardware CRC is off
    assign tx_crc = cfg.crc ? crc_frame(tx_word, nib_n) : datl_ff[3:0];
    assign tx_nib = (nidx_ff == nib_n + 3'h1) ? tx_crc : tx_word[31 - 4*nidx_ff -: 4];
    assign frame_cap = (con3_ff > 16'(FRAME_SAT)) ? 12'(FRAME_SAT) : con3_ff[11:0];

    // Interval length of the current piece in ticks
    always_comb begin
        case (tx_state_ff)
            TX_SYNC: tx_len = 11'(SYNC_TICKS);
            TX_NIB: tx_len = 11'(NIB_BASE) + 11'(tx_nib);
            TX_PAUSE: tx_len = (!cfg.trig && frame_cap >= fticks_ff + 12'(PAUSE_MIN))
                               ? 11'(frame_cap - fticks_ff) : 11'(PAUSE_MIN);
            default: tx_len = 11'h001;
        endcase
    end
    assign tx_last = tick && tcnt_ff == tx_len - 11'h001;

    // Sequencer: sync, status, data, CRC, optional pause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_ff <= TX_IDLE;
            tcnt_ff <= 11'h000;
            nidx_ff <= 3'h0;
            fticks_ff <= 12'h000;
        end else if (!tx_run) begin
            tx_state_ff <= TX_IDLE;
            tcnt_ff <= 11'h000;
        end else if (tick) begin
            tcnt_ff <= tx_last ? 11'h000 : tcnt_ff + 11'h001;
            if (tx_state_ff != TX_PAUSE) fticks_ff <= fticks_ff + 12'h001;
            case (tx_state_ff)
                TX_IDLE: begin
                    if (!cfg.trig || trig_req_ff) begin
                        tx_state_ff <= TX_SYNC;
                        fticks_ff <= 12'h000;
                    end
                end
                TX_SYNC: begin
                    if (tx_last) begin
                        tx_state_ff <= TX_NIB;
                        nidx_ff <= 3'h0;
                    end
                end
                TX_NIB: begin
                    if (tx_last && nidx_ff == nib_n + 3'h1) begin
                        tx_state_ff <= cfg.pause ? TX_PAUSE : (cfg.trig ? TX_IDLE : TX_SYNC);
                        fticks_ff <= cfg.pause ? fticks_ff + 12'h001 : 12'h000;
                    end else if (tx_last) begin
                        nidx_ff <= nidx_ff + 3'h1;
                    end
                end
                TX_PAUSE: begin
                    if (tx_last) begin
                        tx_state_ff <= cfg.trig ? TX_IDLE : TX_SYNC;
                        fticks_ff <= 12'h000;
                    end
                end
                default: tx_state_ff <= TX_IDLE;
            endcase
        end
    end

    // Low pulse opens each interval, idle level follows invert
    assign tx_line = !(tx_state_ff != TX_IDLE && tcnt_ff < 11'(LOW_TICKS));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_tx <= 1'b1;
        end else begin
            link_tx <= tx_line ^ cfg.inv;
        end
    end

    // Trigger request; a new request wins over the consume
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_req_ff <= 1'b0;
        end else if (trig_wr) begin
            trig_req_ff <= 1'b1;
        end else if (tick && tx_state_ff == TX_IDLE && tx_run) begin
            trig_req_ff <= 1'b0;
        end
    end

    // ********************************************************************
    // Receiver
    // ********************************************************************
    snt_rx_state_t rx_state_ff;
    logic rx_s, rx_prev_ff, fall, in_win, nib_ok, rx_done, rx_bad;
    logic [15:0] icnt_ff;
    logic [2:0] ridx_ff;
    logic [31:0] rbuf_ff;
    logic [23:0] t112;
    logic [3:0] rx_val;

    snt_sync u_rx_sync (
        .clk(pclk),
        .rst_n(presetn),
        .din(link_rx),
        .dout(rx_s)
    );

    // Edge detect on the synchronised level only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rx_prev_ff <= 1'b1;
        else rx_prev_ff <= rx_s;
    end
    assign fall = rx_run && rx_prev_ff && !rx_s;

    // Interval counter in prescaled clocks, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) icnt_ff <= 16'h0000;
        else if (fall) icnt_ff <= 16'h0000;
        else if (pre_en && icnt_ff != 16'hFFFF) icnt_ff <= icnt_ff + 16'h0001;
    end

    // Sync window: upper in CON2, lower in CON3
    assign in_win = icnt_ff > con3_ff && icnt_ff < con2_ff;

    // Tick from sync: compare 112*interval against odd half-tick thresholds
    always_comb begin
        t112 = 24'(icnt_ff) * 24'd112;
        rx_val = 4'h0;
        for (int k = 1; k < 16; k++) begin
            if (t112 >= 24'(sync_ff) * 24'(2*k + 2*NIB_BASE - 1)) rx_val = rx_val + 4'h1;
        end
        // Outside 12..27 derived ticks is bad
        nib_ok = t112 >= 24'(sync_ff) * 24'(2*NIB_BASE - 1) && t112 < 24'(sync_ff) * 24'(2*NIB_TOP + 1);
    end

    assign rx_done = fall && rx_state_ff == RX_NIB && nib_ok && ridx_ff == nib_n + 3'h1;
    assign rx_bad = fall && rx_state_ff == RX_NIB && !nib_ok;
    assign frame_event = rx_done;

    // Nibble capture state machine; pause intervals fall outside the window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_ff <= RX_HUNT;
            ridx_ff <= 3'h0;
            rbuf_ff <= 32'h0000_0000;
            sync_ff <= 16'h0000;
        end else if (!rx_run) begin
            rx_state_ff <= RX_HUNT;
        end else if (fall) begin
            case (rx_state_ff)
                RX_HUNT: begin
                    if (in_win) begin
                        sync_ff <= icnt_ff;
                        rx_state_ff <= RX_NIB;
                        ridx_ff <= 3'h0;
                        rbuf_ff <= 32'h0000_0000;
                    end
                end
                RX_NIB: begin
                    if (!nib_ok || rx_done) begin
                        // A bad interval may itself be a fresh sync
                        rx_state_ff <= (!nib_ok && in_win) ? RX_NIB : RX_HUNT;
                        if (!nib_ok && in_win) sync_ff <= icnt_ff;
                        ridx_ff <= 3'h0;
                    end else begin
                        rbuf_ff[31 - 4*ridx_ff -: 4] <= rx_val;
                        ridx_ff <= ridx_ff + 3'h1;
                    end
                end
                default: rx_state_ff <= RX_HUNT;
            endcase
        end
    end

    // Data registers: a completed frame wins over a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            datl_ff <= DAT_RST;
            dath_ff <= DAT_RST;
        end else if (rx_done) begin
            dath_ff <= rbuf_ff[31:16];
            datl_ff <= {rbuf_ff[15:4], rx_val};
        end else if (wr_en) begin
            if (paddr == OFF_DATL) datl_ff <= pwdata[15:0];
            if (paddr == OFF_DATH) dath_ff <= pwdata[15:0];
        end
    end

    // Sticky flags, write one to clear, set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ff <= 1'b0;
            ferr_ff <= 1'b0;
            cerr_ff <= 1'b0;
        end else begin
            if (rx_done || (tx_last && tx_state_ff == TX_NIB && nidx_ff == nib_n + 3'h1)) done_ff <= 1'b1;
            else if (trig_wr || (wr_en && paddr == OFF_STAT && pwdata[S_DONE])) done_ff <= 1'b0;
            if (rx_bad) ferr_ff <= 1'b1;
            else if (wr_en && paddr == OFF_STAT && pwdata[S_FERR]) ferr_ff <= 1'b0;
            if (rx_done && cfg.crc && crc_frame(rbuf_ff, nib_n) != rx_val) cerr_ff <= 1'b1;
            else if (wr_en && paddr == OFF_STAT && pwdata[S_CERR]) cerr_ff <= 1'b0;
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sync_width_a: assert property (tx_state_ff == TX_SYNC |-> tx_len == 11'd56)
        else $error("sync length is not 56 ticks");
    sync_exit_a: assert property (tx_run && tx_last && tx_state_ff == TX_SYNC |=> tx_state_ff == TX_NIB)
        else $error("sync not followed by status nibble");
    nib_width_a: assert property (tx_state_ff == TX_NIB |-> tx_len >= 11'd12 && tx_len <= 11'd27)
        else $error("nibble interval out of range");
    pause_floor_a: assert property (tx_state_ff == TX_PAUSE |-> tx_len >= 11'd12 && tx_len <= 11'd2047)
        else $error("pause length out of range");
    nib_count_a: assert property (tx_state_ff == TX_NIB |-> nidx_ff <= 3'd7 && nidx_ff <= nib_n + 3'd1)
        else $error("nibble index past CRC");
    recv_idle_a: assert property (cfg.recv |=> tx_state_ff == TX_IDLE ##1 link_tx == !$past(cfg.inv))
        else $error("transmitter active in receive mode");
    trig_hold_a: assert property (tx_state_ff == TX_IDLE && cfg.trig && !trig_req_ff && !trig_wr |=>
        tx_state_ff == TX_IDLE) else $error("triggered mode started without request");
    sync_take_a: assert property (fall && rx_state_ff == RX_HUNT && in_win |=>
        rx_state_ff == RX_NIB && sync_ff == $past(icnt_ff)) else $error("valid sync not captured");
    frame_drop_a: assert property (rx_bad && !in_win |=> ferr_ff && rx_state_ff == RX_HUNT)
        else $error("bad nibble not flagged");
    rx_done_a: assert property (rx_done |=> done_ff && datl_ff[3:0] == $past(rx_val))
        else $error("completed frame not reported");
endmodule
`default_nettype wire

// *** snt_pkg.sv ***
// Shared constants, register map and types for the nibble link unit
package snt_pkg;
    // ********************************************************************
    // Register byte offsets
    // ********************************************************************
    localparam logic [7:0] OFF_CON1 = 8'h00;
    localparam logic [7:0] OFF_CON2 = 8'h04;
    localparam logic [7:0] OFF_CON3 = 8'h08;
    localparam logic [7:0] OFF_DATL = 8'h0C;
    localparam logic [7:0] OFF_DATH = 8'h10;
    localparam logic [7:0] OFF_SYNC = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    // ********************************************************************
    // Field positions and reset values
    // ********************************************************************
    localparam int B_ENABLE = 15;
    localparam int B_RECV = 11;
    localparam int B_TRIG = 10;
    localparam int B_INV = 9;
    localparam int B_CRC = 8;
    localparam int B_PAUSE = 7;
    localparam int B_DIV = 4;
    localparam int B_NIB = 0;
    localparam logic [15:0] CON1_MASK = 16'h8F97;
    localparam logic [15:0] CON1_RST = 16'h0000;
    localparam logic [15:0] CON2_RST = 16'h0000;
    localparam logic [15:0] CON3_RST = 16'h0000;
    localparam logic [15:0] DAT_RST = 16'h0000;
    localparam int S_DONE = 0;
    localparam int S_FERR = 1;
    localparam int S_CERR = 2;
    localparam int S_TXBUSY = 3;
    localparam int S_RXBUSY = 4;
    localparam int S_TRIG = 8;
    // ********************************************************************
    // Frame timing in ticks, nibble count limits, prescaler and CRC constants
    // ********************************************************************
    localparam int SYNC_TICKS = 56;
    localparam int NIB_BASE = 12;
    localparam int NIB_TOP = 27;
    localparam int PAUSE_MIN = 12;
    localparam int FRAME_SAT = 2047;
    localparam int LOW_TICKS = 5;
    localparam int MIN_NIB = 3;
    localparam int MAX_NIB = 6;
    localparam int PRESCALE_DIV = 4;
    localparam logic [3:0] CRC_SEED = 4'h5;
    localparam logic [3:0] CRC_POLY = 4'hD;

    typedef enum {TX_IDLE, TX_SYNC, TX_NIB, TX_PAUSE} snt_tx_state_t;
    typedef enum {RX_HUNT, RX_NIB} snt_rx_state_t;

    // Decoded view of the first control register
    typedef struct packed {
        logic enable;
        logic recv;
        logic trig;
        logic inv;
        logic crc;
        logic pause;
        logic div4;
        logic [2:0] nib;
    } snt_cfg_t;
endpackage

// *** snt_sensor.sv ***
// Behavioural far-end sensor that sends one link frame when asked
`timescale 1ns/1ps
`default_nettype none
module snt_sensor (
    input wire logic clk,
    input wire logic go,
    input wire logic [15:0] tk,
    input wire logic [31:0] word,
    input wire logic [2:0] cnt,
    input wire logic bad,
    output logic line,
    output logic busy
);
    // One interval: short low pulse, then high for the rest
    task automatic ivl(input int n);
        line <= 1'b0;
        repeat (5 * tk) @(posedge clk);
        line <= 1'b1;
        repeat ((n - 5) * tk) @(posedge clk);
    endtask
    // sync, status, data, CRC in ticks
    initial begin
        line = 1'b1;  // Idle high, as the pull-up leaves it
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                ivl(56);
                for (int i = 0; i <= cnt; i++) begin
                    // Bad width only when a scenario asks for it
                    ivl((bad && i == 2) ? 30 : 12 + word[31 - 4 * i -: 4]);
                end
                ivl(12 + word[3:0]);
                // Closing edge ends the CRC interval
                ivl(12);
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** snt_sync.sv ***
// Two-stage synchroniser for an asynchronous pin
`timescale 1ns/1ps
`default_nettype none
module snt_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic meta_ff;
    // ********************************************************************
    // Two flops; resets to the idle-high line level
    // ********************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b1;
            dout <= 1'b1;
        end else begin
            meta_ff <= din;
            dout <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// *** snt_tick.sv ***
// Prescaler and tick divider producing one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module snt_tick import snt_pkg::*; #(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic div4,
    input wire logic [CNT_W-1:0] divider,
    output logic pre_en,
    output logic tick
);
    logic [1:0] pre_cnt_ff;
    logic [CNT_W-1:0] div_cnt_ff;

    assign pre_en = run && (!div4 || pre_cnt_ff == 2'(PRESCALE_DIV - 1));
    // Tick every divider+1 prescaled clocks
    // A divider lowered mid-count must not leave the counter wrapping past it
    assign tick = pre_en && div_cnt_ff >= divider;

    // Prescaler counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_ff <= 2'h0;
        end else if (!run || pre_en) begin
            pre_cnt_ff <= 2'h0;
        end else begin
            pre_cnt_ff <= pre_cnt_ff + 2'h1;
        end
    end

    // Tick counter restarts whenever the link stops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_ff <= '0;
        end else if (!run || tick) begin
            div_cnt_ff <= '0;
        end else if (pre_en) begin
            div_cnt_ff <= div_cnt_ff + 1'b1;
        end
    end

    tick_spacing_a: assert property (@(posedge clk) disable iff (!rst_n)
        tick && divider != '0 && run |=> !tick) else $error("tick spacing shorter than divider");
endmodule
`default_nettype wire

// *** test_sent_nibble_link_txrx.sv ***
// Self-checking bench for the nibble link unit
`timescale 1ns/1ps
`default_nettype none
module test_sent_nibble_link_txrx;
    import snt_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, bad = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_d, word = 32'h3A5F0C19;
    logic pready, pslverr, link_rx, link_tx, frame_event, busy, err_d;
    logic [15:0] tk = 16'h0004;
    logic [2:0] cnt = 3'h3;
    int mismatches = 0, tests_run = 0, cyc = 0, evs = 0, e0, g;
    int ivl_t[7] = '{56, 15, 22, 17, 27, 21, 56};
    int fl[3] = '{200, 65535, 100}, pz[3] = '{38, 1885, 12}, falls = 0;
    logic ltx_q = 1'b1;
    always #2.5 pclk = ~pclk;
    snt_link dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_rx(link_rx), .link_tx(link_tx), .frame_event(frame_event));
    snt_sensor peer (.clk(pclk), .go(go), .tk(tk), .word(word), .cnt(cnt), .bad(bad),
        .line(link_rx), .busy(busy));
    // Hang guard and event counter
    always @(posedge pclk) begin
        cyc++;
        if (frame_event === 1'b1) evs++;
        if (ltx_q === 1'b1 && link_tx === 1'b0) falls++;
        ltx_q = link_tx;
        if (cyc == 40000) begin
            mismatches++;
            stop_test;
        end
    end
    task stop_test;
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // APB transfer; holds the request until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d}; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_d = prdata;
        err_d = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Cycles up to the next falling edge of the transmit pin
    task gap(output int n);
        logic p;
        n = 0;
        #1;
        do begin
            p = link_tx;
            @(posedge pclk);
            #1;
            n++;
        end while (!(p === 1'b1 && link_tx === 1'b0));
    endtask
    // Ask the sensor for one frame and let it finish
    task send;
        e0 = evs;
        @(posedge pclk) go <= 1'b1;
        @(posedge pclk) go <= 1'b0;
        @(posedge pclk);
        while (busy) @(posedge pclk);
        repeat (20) @(posedge pclk);
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFF_CON1, 0); chk(rd_d, {16'h0000, CON1_RST});
        chk(link_tx, 1);
        apb(1, OFF_CON1, 16'h0200); repeat (3) @(posedge pclk); #1 chk(link_tx, 0);
        apb(1, OFF_CON1, 16'hFFFF); apb(0, OFF_CON1, 0); chk(rd_d, {16'h0000, CON1_MASK});
        apb(1, OFF_CON1, 0); apb(0, 8'h40, 0); chk({err_d, rd_d[30:0]}, 32'h80000000);
        // Continuous transmit, tick of two prescaled clocks, both prescaler settings
        apb(1, OFF_CON2, 1); apb(1, OFF_DATL, 16'h0009);
        for (int d = 0; d < 2; d++) begin
            apb(1, OFF_DATH, 16'h3A5F); apb(1, OFF_CON1, 16'h8003 | (d << B_DIV));
            gap(g);
            for (int i = 0; i < 7; i++) begin
                gap(g); chk(g, ivl_t[i] * 2 * (d ? PRESCALE_DIV : 1));
            end
            // New status loaded inside the sync of the following frame
            for (int i = 0; i < 5; i++) gap(g);
            apb(1, OFF_DATH, 16'h7A5F); gap(g);
            gap(g); chk(g, 19 * 2 * (d ? PRESCALE_DIV : 1));
            apb(1, OFF_CON1, 0);
        end
        // One clock per tick; frame of 200, above the cap, below the minimum
        apb(1, OFF_CON2, 0);
        for (int j = 0; j < 3; j++) begin
            apb(1, OFF_CON3, fl[j]); apb(1, OFF_CON1, 16'h8083);
            for (int i = 0; i < 7; i++) gap(g);
            gap(g); chk(g, pz[j]);
            apb(1, OFF_CON1, 0);
        end
        // Triggered mode waits for software, then sends exactly one frame
        apb(1, OFF_CON1, 16'h8483); e0 = falls; repeat (100) @(posedge pclk); chk(falls - e0, 0);
        apb(1, OFF_STAT, 16'h0100); repeat (400) @(posedge pclk); chk(falls - e0, 7);
        apb(1, OFF_CON1, 0);
        // Receive with a window around 224 clocks, three then six nibbles
        apb(1, OFF_CON2, 16'd269); apb(1, OFF_CON3, 16'd179);
        for (int n = 3; n <= 6; n += 3) begin
            apb(1, OFF_CON1, 16'h8800 | n); cnt <= n[2:0];
            apb(1, OFF_STAT, 16'h0007);
            send;
            chk(evs - e0, 1);
            apb(0, OFF_DATH, 0); chk(rd_d, 32'h3A5F);
            apb(0, OFF_DATL, 0); chk(rd_d & (n == 6 ? 32'hFFFF : 32'hF), word & (n == 6 ? 32'hFFFF : 32'hF));
            apb(0, OFF_SYNC, 0); chk(rd_d >= 222 && rd_d <= 226, 1);
            apb(0, OFF_STAT, 0); chk(rd_d[1:0], 2'b01);
        end
        // Nibble wider than 27 ticks drops the frame
        bad <= 1'b1;
        apb(1, OFF_STAT, 16'h0007);
        send;
        chk(evs - e0, 0);
        apb(0, OFF_STAT, 0); chk(rd_d[1:0], 2'b10);
        stop_test;
    end
endmodule
`default_nettype wire
